/* File: include/plr_pkg.sv */
// Package for the plane and memory power-limit register bank.
// Assumes a 200 MHz core clock and a 32-bit APB master on the same clock.
package plr_pkg;

    // Byte addresses of the APB words.
    localparam logic [7:0] CORE_LIM_ADDR = 8'h00;
    localparam logic [7:0] CORE_ENG_ADDR = 8'h04;
    localparam logic [7:0] CORE_PRI_ADDR = 8'h08;
    localparam logic [7:0] CORE_THR_ADDR = 8'h0C;
    localparam logic [7:0] UNC_LIM_ADDR = 8'h10;
    localparam logic [7:0] UNC_ENG_ADDR = 8'h14;
    localparam logic [7:0] UNC_PRI_ADDR = 8'h18;
    localparam logic [7:0] MEM_LIM_ADDR = 8'h20;
    localparam logic [7:0] MEM_ENG_ADDR = 8'h24;
    localparam logic [7:0] RANGE_LO_ADDR = 8'h28;
    localparam logic [7:0] RANGE_HI_ADDR = 8'h2C;
    localparam logic [7:0] MEM_THR_ADDR = 8'h30;

    // Field positions inside a limit word and a priority word.
    localparam int LIM_LSB = 0;
    localparam int LIM_W = 15;
    localparam int EN_BIT = 15;
    localparam int CLAMP_BIT = 16;
    localparam int WIN_LSB = 17;
    localparam int WIN_W = 7;
    localparam int WIN_Y_W = 5;
    localparam int LOCK_BIT = 31;
    localparam int PRI_W = 5;
    localparam int RANGE_HI_LSB = 16;

    // Writable bits; everything else reads as zero.
    localparam logic [31:0] PLANE_LIM_MASK = 32'h80FF_FFFF;
    localparam logic [31:0] MEM_LIM_MASK = 32'h80FE_FFFF;

    // Reset values. The uncore plane outranks the core plane by default.
    localparam logic [31:0] LIM_RST = 32'h0000_0000;
    localparam logic [4:0] CORE_PRI_RST = 5'h08;
    localparam logic [4:0] UNC_PRI_RST = 5'h10;

    // Memory power range, in power units and time units.
    localparam logic [14:0] MEM_TDP_PWR = 15'h0100;
    localparam logic [14:0] MEM_MIN_PWR = 15'h0040;
    localparam logic [14:0] MEM_MAX_PWR = 15'h0200;
    localparam logic [5:0] MEM_MAX_WIN = 6'h28;

    // Timing.
    localparam int CLK_PERIOD_NS = 5;
    localparam int REFRESH_NS = 1000000;
    localparam logic [27:0] REFRESH_CYCLES = 28'(REFRESH_NS / CLK_PERIOD_NS);
    localparam logic [27:0] CLK_HZ = 28'(1000000000 / CLK_PERIOD_NS);

endpackage

/* File: design/plr_accum.sv */
// 32-bit accumulator that sums increments and publishes the total on a strobe.
// Assumes increments come from logic on the same clock.
`timescale 1ns/10ps
module plr_accum (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [15:0] inc_in,
    input wire logic pub_in,
    output logic [31:0] total_out
);
    logic [31:0] shadow;
    logic [31:0] next_shadow;

    // The sum wraps modulo 2^32 with no flag.
    assign next_shadow = shadow + {16'h0000, inc_in};

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            shadow <= 32'h0000_0000;
        end else if (ce_in) begin
            shadow <= next_shadow;
        end
    end

    // Software sees the total only at publish strobes.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            total_out <= 32'h0000_0000;
        end else if (ce_in && pub_in) begin
            total_out <= next_shadow;
        end
    end
endmodule // plr_accum

/* File: design/plr_win.sv */
// Decoder of a 7-bit time-window field into tenths of a time unit.
// Assumes the field comes from a register on the same clock.
`timescale 1ns/10ps
module plr_win import plr_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [6:0] field_in,
    output logic [35:0] tenths_out
);
    logic [35:0] base;
    logic [1:0] frac;

    assign base = 36'h0_0000_0001 << field_in[WIN_Y_W-1:0];
    assign frac = field_in[WIN_W-1:WIN_Y_W];

    // Window = 2^Y * 1.F, so tenths = 2^Y * (10 + F); fits 35 bits.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tenths_out <= 36'h0_0000_0000;
        end else if (ce_in) begin
            tenths_out <= (base << 3) + (base << 1) + (frac[1] ? (base << 1) : 36'h0)
                + (frac[0] ? base : 36'h0);
        end
    end
endmodule // plr_win

/* File: design/plr_regs.sv */
// Power-limit register bank for the core plane, uncore plane and memory.
// Assumes an APB master and energy/throttle sources on SYS_CLK_IN.
// Notes on behaviour
// - Plane limit word holds a 15-bit average power limit in bits 14:0.
// - Bit 15 of each plane limit enables limiting when one.
// - Clamp bit lets the plane drop below the requested state in-window.
// - Plane window is 2^Y times 1.F time units, Y low five bits.
// - Plane lock ignores writes to its limit and priority until reset.
// - Core and uncore planes lock independently.
// - Plane energy totals are read-only, 32-bit, refreshed each millisecond.
// - Plane priority is five bits; 31 is highest.
// - Default priorities favour the uncore plane over the core plane.
// - Core throttle time is read-only, 32-bit, in time units.
// - Core throttle exists only on server; uncore absent on server.
// - Memory limit holds a 15-bit limit and an enable bit.
// - Memory window uses the same 2^Y times 1.F encoding.
// - Memory lock ignores writes to the memory limit until reset.
// - Memory energy total is read-only, 32-bit, refreshed each millisecond.
// - Memory range reports thermal, minimum and maximum power read-only.
// - Range reports the largest window; software must not exceed it.
// - Memory throttle time is read-only, 32-bit, in time units.
// - Time unit is one second over two to the unit field.
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/10ps
module plr_regs import plr_pkg::*; #(
    parameter logic [27:0] MS_CYCLES = REFRESH_CYCLES,
    parameter logic [27:0] UNIT_BASE_CYCLES = CLK_HZ,
    parameter bit SERVER_CFG = 1'b0
) (
    input wire logic SYS_CLK_IN,
    input wire logic RST_IN,
    input wire logic CE_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [3:0] PSTRB_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic [3:0] UNIT_TIME_IN,
    input wire logic [15:0] CORE_ENERGY_INC_IN,
    input wire logic [15:0] UNCORE_ENERGY_INC_IN,
    input wire logic [15:0] MEM_ENERGY_INC_IN,
    input wire logic CORE_THROTTLED_IN,
    input wire logic MEM_THROTTLED_IN,
    output logic [14:0] CORE_LIMIT_OUT,
    output logic CORE_LIMIT_EN_OUT,
    output logic CORE_CLAMP_OUT,
    output logic [35:0] CORE_WINDOW_OUT,
    output logic [4:0] CORE_PRIORITY_OUT,
    output logic [14:0] UNCORE_LIMIT_OUT,
    output logic UNCORE_LIMIT_EN_OUT,
    output logic UNCORE_CLAMP_OUT,
    output logic [35:0] UNCORE_WINDOW_OUT,
    output logic [4:0] UNCORE_PRIORITY_OUT,
    output logic [14:0] MEM_LIMIT_OUT,
    output logic MEM_LIMIT_EN_OUT,
    output logic [35:0] MEM_WINDOW_OUT
);
    logic [31:0] core_lim;
    logic [31:0] unc_lim;
    logic [31:0] mem_lim;
    logic [4:0] core_pri;
    logic [4:0] unc_pri;
    logic [31:0] core_eng;
    logic [31:0] unc_eng;
    logic [31:0] mem_eng;
    logic [31:0] core_thr;
    logic [31:0] mem_thr;
    logic [27:0] ms_cnt;
    logic [27:0] unit_cnt;
    logic [27:0] unit_period;
    logic ms_tick;
    logic unit_tick;
    logic setup;
    logic wr_acc;
    logic wr_core_lim;
    logic wr_unc_lim;
    logic wr_mem_lim;
    logic wr_core_pri;
    logic wr_unc_pri;
    logic [31:0] rd_data;
    logic rd_ok;

    // Byte-lane merge of a write word, then the writable-bit mask.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r & mask;
    endfunction

    // The slave never inserts wait states; read data is captured in setup.
    assign PREADY_OUT = 1'b1;
    assign setup = PSEL_IN && !PENABLE_IN;
    assign wr_acc = PSEL_IN && PENABLE_IN && PWRITE_IN;

    // A set lock bit blocks the write that would clear it, so it holds to reset.
    assign wr_core_lim = wr_acc && (PADDR_IN == CORE_LIM_ADDR) && !core_lim[LOCK_BIT];
    assign wr_unc_lim = wr_acc && (PADDR_IN == UNC_LIM_ADDR) && !SERVER_CFG
        && !unc_lim[LOCK_BIT];
    assign wr_mem_lim = wr_acc && (PADDR_IN == MEM_LIM_ADDR) && SERVER_CFG
        && !mem_lim[LOCK_BIT];
    assign wr_core_pri = wr_acc && (PADDR_IN == CORE_PRI_ADDR) && !core_lim[LOCK_BIT];
    assign wr_unc_pri = wr_acc && (PADDR_IN == UNC_PRI_ADDR) && !SERVER_CFG
        && !unc_lim[LOCK_BIT];

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            core_lim <= LIM_RST;
        end else if (CE_IN && wr_core_lim) begin
            core_lim <= merge(core_lim, PWDATA_IN, PSTRB_IN, PLANE_LIM_MASK);
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            unc_lim <= LIM_RST;
        end else if (CE_IN && wr_unc_lim) begin
            unc_lim <= merge(unc_lim, PWDATA_IN, PSTRB_IN, PLANE_LIM_MASK);
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            mem_lim <= LIM_RST;
        end else if (CE_IN && wr_mem_lim) begin
            mem_lim <= merge(mem_lim, PWDATA_IN, PSTRB_IN, MEM_LIM_MASK);
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            core_pri <= CORE_PRI_RST;
            unc_pri <= UNC_PRI_RST;
        end else if (CE_IN) begin
            if (wr_core_pri && PSTRB_IN[0]) begin
                core_pri <= PWDATA_IN[PRI_W-1:0];
            end
            if (wr_unc_pri && PSTRB_IN[0]) begin
                unc_pri <= PWDATA_IN[PRI_W-1:0];
            end
        end
    end

    // Limiter controls. Clamping is only granted while limiting is enabled.
    assign CORE_LIMIT_OUT = core_lim[LIM_LSB +: LIM_W];
    assign CORE_LIMIT_EN_OUT = core_lim[EN_BIT];
    assign CORE_CLAMP_OUT = core_lim[EN_BIT] && core_lim[CLAMP_BIT];
    assign CORE_PRIORITY_OUT = core_pri;
    assign UNCORE_LIMIT_OUT = unc_lim[LIM_LSB +: LIM_W];
    assign UNCORE_LIMIT_EN_OUT = unc_lim[EN_BIT];
    assign UNCORE_CLAMP_OUT = unc_lim[EN_BIT] && unc_lim[CLAMP_BIT];
    assign UNCORE_PRIORITY_OUT = unc_pri;
    assign MEM_LIMIT_OUT = mem_lim[LIM_LSB +: LIM_W];
    assign MEM_LIMIT_EN_OUT = mem_lim[EN_BIT];

    plr_win u_core_win (
        .clk_in(SYS_CLK_IN),
        .rst_in(RST_IN),
        .ce_in(CE_IN),
        .field_in(core_lim[WIN_LSB +: WIN_W]),
        .tenths_out(CORE_WINDOW_OUT)
    );

    plr_win u_unc_win (
        .clk_in(SYS_CLK_IN),
        .rst_in(RST_IN),
        .ce_in(CE_IN),
        .field_in(unc_lim[WIN_LSB +: WIN_W]),
        .tenths_out(UNCORE_WINDOW_OUT)
    );

    plr_win u_mem_win (
        .clk_in(SYS_CLK_IN),
        .rst_in(RST_IN),
        .ce_in(CE_IN),
        .field_in(mem_lim[WIN_LSB +: WIN_W]),
        .tenths_out(MEM_WINDOW_OUT)
    );

    // Millisecond refresh strobe for the energy totals.
    assign ms_tick = (ms_cnt == MS_CYCLES - 28'h000_0001);

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            ms_cnt <= 28'h000_0000;
        end else if (CE_IN) begin
            ms_cnt <= ms_tick ? 28'h000_0000 : ms_cnt + 28'h000_0001;
        end
    end

    // One time unit is one second shifted down by the unit field.
    assign unit_period = UNIT_BASE_CYCLES >> UNIT_TIME_IN;
    assign unit_tick = (unit_cnt >= unit_period - 28'h000_0001);

    // A unit-field change mid-count only stretches or cuts one unit.
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            unit_cnt <= 28'h000_0000;
        end else if (CE_IN) begin
            unit_cnt <= unit_tick ? 28'h000_0000 : unit_cnt + 28'h000_0001;
        end
    end

    plr_accum u_core_eng (
        .clk_in(SYS_CLK_IN),
        .rst_in(RST_IN),
        .ce_in(CE_IN),
        .inc_in(CORE_ENERGY_INC_IN),
        .pub_in(ms_tick),
        .total_out(core_eng)
    );

    plr_accum u_unc_eng (
        .clk_in(SYS_CLK_IN),
        .rst_in(RST_IN),
        .ce_in(CE_IN),
        .inc_in(UNCORE_ENERGY_INC_IN),
        .pub_in(ms_tick),
        .total_out(unc_eng)
    );

    plr_accum u_mem_eng (
        .clk_in(SYS_CLK_IN),
        .rst_in(RST_IN),
        .ce_in(CE_IN),
        .inc_in(MEM_ENERGY_INC_IN),
        .pub_in(ms_tick),
        .total_out(mem_eng)
    );

    // Throttle time counts units whose last cycle finds the plane throttled and is visible at once.
    plr_accum u_core_thr (
        .clk_in(SYS_CLK_IN),
        .rst_in(RST_IN),
        .ce_in(CE_IN),
        .inc_in({15'h0000, CORE_THROTTLED_IN && unit_tick}),
        .pub_in(1'b1),
        .total_out(core_thr)
    );

    plr_accum u_mem_thr (
        .clk_in(SYS_CLK_IN),
        .rst_in(RST_IN),
        .ce_in(CE_IN),
        .inc_in({15'h0000, MEM_THROTTLED_IN && unit_tick}),
        .pub_in(1'b1),
        .total_out(mem_thr)
    );

    // Read decode. Words absent in this configuration answer with an error.
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b1;
        unique case (PADDR_IN)
            CORE_LIM_ADDR: rd_data = core_lim;
            CORE_ENG_ADDR: rd_data = core_eng;
            CORE_PRI_ADDR: rd_data = {27'h000_0000, core_pri};
            CORE_THR_ADDR: begin
                rd_ok = SERVER_CFG;
                rd_data = SERVER_CFG ? core_thr : 32'h0000_0000;
            end
            UNC_LIM_ADDR: begin
                rd_ok = !SERVER_CFG;
                rd_data = SERVER_CFG ? 32'h0000_0000 : unc_lim;
            end
            UNC_ENG_ADDR: begin
                rd_ok = !SERVER_CFG;
                rd_data = SERVER_CFG ? 32'h0000_0000 : unc_eng;
            end
            UNC_PRI_ADDR: begin
                rd_ok = !SERVER_CFG;
                rd_data = SERVER_CFG ? 32'h0000_0000 : {27'h000_0000, unc_pri};
            end
            MEM_LIM_ADDR: begin
                rd_ok = SERVER_CFG;
                rd_data = SERVER_CFG ? mem_lim : 32'h0000_0000;
            end
            MEM_ENG_ADDR: begin
                rd_ok = SERVER_CFG;
                rd_data = SERVER_CFG ? mem_eng : 32'h0000_0000;
            end
            RANGE_LO_ADDR: begin
                rd_ok = SERVER_CFG;
                rd_data = SERVER_CFG ? {1'b0, MEM_MIN_PWR, 1'b0, MEM_TDP_PWR}
                    : 32'h0000_0000;
            end
            RANGE_HI_ADDR: begin
                rd_ok = SERVER_CFG;
                rd_data = SERVER_CFG ? {10'h000, MEM_MAX_WIN, 1'b0, MEM_MAX_PWR}
                    : 32'h0000_0000;
            end
            MEM_THR_ADDR: begin
                rd_ok = SERVER_CFG;
                rd_data = SERVER_CFG ? mem_thr : 32'h0000_0000;
            end
            default: rd_ok = 1'b0;
        endcase
    end

    // Answer registered in setup so the access phase sees stable flops.
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            PRDATA_OUT <= 32'h0000_0000;
            PSLVERR_OUT <= 1'b0;
        end else if (CE_IN && setup) begin
            PRDATA_OUT <= PWRITE_IN ? 32'h0000_0000 : rd_data;
            PSLVERR_OUT <= !rd_ok;
        end
    end

    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (RST_IN);

    core_lock_hold_a: assert property (CE_IN && core_lim[LOCK_BIT] |=>
        core_lim[LOCK_BIT] && $stable(core_lim)) else $error("core limit changed while locked");
    pri_lock_hold_a: assert property (CE_IN && core_lim[LOCK_BIT] && wr_acc
        && PADDR_IN == CORE_PRI_ADDR |=> $stable(core_pri))
        else $error("core priority written while locked");
    uncore_free_a: assert property (CE_IN && wr_acc && PADDR_IN == UNC_LIM_ADDR
        && !SERVER_CFG && !unc_lim[LOCK_BIT] && core_lim[LOCK_BIT] && PSTRB_IN == 4'hF
        |=> unc_lim == ($past(PWDATA_IN) & PLANE_LIM_MASK))
        else $error("uncore write lost under core lock");
    mem_lock_hold_a: assert property (CE_IN && mem_lim[LOCK_BIT] |=> $stable(mem_lim))
        else $error("memory limit changed while locked");
    energy_hold_a: assert property (!(CE_IN && ms_tick) |=> $stable(core_eng))
        else $error("energy total moved between refreshes");
    throttle_step_a: assert property (CE_IN && unit_tick && CORE_THROTTLED_IN
        |=> core_thr == $past(core_thr) + 32'h0000_0001)
        else $error("throttle time not advanced by one unit");
    absent_err_a: assert property (CE_IN && setup && (PADDR_IN == UNC_LIM_ADDR)
        && SERVER_CFG |=> PSLVERR_OUT) else $error("absent uncore word gave no error");
    prio_default_a: assert property ($past(RST_IN) |-> unc_pri > core_pri)
        else $error("uncore default priority not above core");
    clamp_gate_a: assert property (CORE_CLAMP_OUT |-> core_lim[EN_BIT])
        else $error("clamp granted while limiting disabled");

    lock_cov_c: cover property (wr_acc && PADDR_IN == CORE_LIM_ADDR && core_lim[LOCK_BIT]);
    refresh_cov_c: cover property (CE_IN && ms_tick ##1 core_eng != 32'h0000_0000);
    throttle_cov_c: cover property (CE_IN && unit_tick && CORE_THROTTLED_IN);
    err_cov_c: cover property (PSLVERR_OUT && PENABLE_IN);
endmodule // plr_regs

/* File: verification/power_plane_limit_regs_tb.sv */
// Self-checking bench for the plane and memory power-limit register bank.
// Assumes plr_pkg is compiled first; a client and a server instance share the stimulus.
`timescale 1ns/10ps
module power_plane_limit_regs_tb import plr_pkg::*; ;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic psel_c = 1'b0;
    logic psel_s = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic srv = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hF;
    logic [3:0] unit = 4'h6;
    logic [15:0] inc_c = 16'h0000;
    logic [15:0] inc_u = 16'h0000;
    logic [15:0] inc_m = 16'h0000;
    logic thr_c = 1'b0;
    logic thr_m = 1'b0;
    logic [31:0] rd_c, rd_s, d;
    logic rdy_c, rdy_s, err_c, err_s, en_c, clamp_c, en_m, en_u, clamp_u;
    logic [14:0] lim_c, lim_m, lim_u;
    logic [35:0] win_c, win_m, win_u;
    logic [4:0] pri_c, pri_u;
    logic [32:0] exp_q[$];
    int num_errors = 0;
    int check_count = 0;
    int seed = 18921;

    // Short counts keep the run small: 20-cycle refresh, unit base of 64 cycles.
    plr_regs #(.MS_CYCLES(28'd20), .UNIT_BASE_CYCLES(28'd64)) u_dut (
        .SYS_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .PSEL_IN(psel_c), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
        .PRDATA_OUT(rd_c), .PREADY_OUT(rdy_c), .PSLVERR_OUT(err_c), .UNIT_TIME_IN(unit),
        .CORE_ENERGY_INC_IN(inc_c), .UNCORE_ENERGY_INC_IN(inc_u), .MEM_ENERGY_INC_IN(inc_m),
        .CORE_THROTTLED_IN(thr_c), .MEM_THROTTLED_IN(thr_m), .CORE_LIMIT_OUT(lim_c),
        .CORE_LIMIT_EN_OUT(en_c), .CORE_CLAMP_OUT(clamp_c), .CORE_WINDOW_OUT(win_c),
        .CORE_PRIORITY_OUT(pri_c), .UNCORE_LIMIT_OUT(lim_u), .UNCORE_LIMIT_EN_OUT(en_u),
        .UNCORE_CLAMP_OUT(clamp_u), .UNCORE_WINDOW_OUT(win_u), .UNCORE_PRIORITY_OUT(pri_u),
        .MEM_LIMIT_OUT(), .MEM_LIMIT_EN_OUT(), .MEM_WINDOW_OUT());

    plr_regs #(.MS_CYCLES(28'd20), .UNIT_BASE_CYCLES(28'd64), .SERVER_CFG(1'b1)) u_dut_srv (
        .SYS_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .PSEL_IN(psel_s), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
        .PRDATA_OUT(rd_s), .PREADY_OUT(rdy_s), .PSLVERR_OUT(err_s), .UNIT_TIME_IN(unit),
        .CORE_ENERGY_INC_IN(inc_c), .UNCORE_ENERGY_INC_IN(inc_u), .MEM_ENERGY_INC_IN(inc_m),
        .CORE_THROTTLED_IN(thr_c), .MEM_THROTTLED_IN(thr_m), .CORE_LIMIT_OUT(),
        .CORE_LIMIT_EN_OUT(), .CORE_CLAMP_OUT(), .CORE_WINDOW_OUT(),
        .CORE_PRIORITY_OUT(), .UNCORE_LIMIT_OUT(), .UNCORE_LIMIT_EN_OUT(),
        .UNCORE_CLAMP_OUT(), .UNCORE_WINDOW_OUT(), .UNCORE_PRIORITY_OUT(),
        .MEM_LIMIT_OUT(lim_m), .MEM_LIMIT_EN_OUT(en_m), .MEM_WINDOW_OUT(win_m));

    always #2.5 clk = ~clk;

    function automatic logic [35:0] win(input logic [6:0] f);
        return (36'd10 + 36'(f[6:5])) << f[4:0];
    endfunction

    task automatic check(input logic [35:0] seen, input logic [35:0] expv);
        check_count++;
        if (seen !== expv) begin
            num_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic report_and_stop;
        if (num_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One APB transfer; reads leave their expected {error, data} in the queue.
    task automatic apb(input logic s, input logic w, input logic [7:0] ad,
                       input logic [31:0] dt, input logic [3:0] st, input logic [32:0] ex);
        @(posedge clk);
        if (!w) begin
            exp_q.push_back(ex);
        end
        srv <= s;
        psel_c <= !s;
        psel_s <= s;
        pwrite <= w;
        paddr <= ad;
        pwdata <= dt;
        pstrb <= st;
        penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for ready, so a stuck slave fails the run.
        do begin
            @(posedge clk);
        end while ((s ? rdy_s : rdy_c) !== 1'b1);
        psel_c <= 1'b0;
        psel_s <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic s, input logic [7:0] ad, input logic [31:0] dt);
        apb(s, 1'b1, ad, dt, 4'hF, 33'h0_0000_0000);
    endtask

    task automatic rd(input logic s, input logic [7:0] ad, input logic [32:0] ex);
        apb(s, 1'b0, ad, 32'h0000_0000, 4'hF, ex);
    endtask

    task automatic do_reset;
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
    endtask

    // Read data is judged at the access edge, where PRDATA has stood since setup.
    always @(posedge clk) begin
        if ((psel_c | psel_s) && penable && !pwrite && (srv ? rdy_s : rdy_c) === 1'b1) begin
            check(srv ? {3'b000, err_s, rd_s} : {3'b000, err_c, rd_c}, {3'b000, exp_q.pop_front()});
        end
    end

    initial begin
        #100000;
        num_errors++;
        report_and_stop();
    end

    initial begin
        do_reset();
        repeat (2) @(posedge clk);
        #1;
        check(win_c, 36'd10);
        check(36'(pri_c), 36'(CORE_PRI_RST));
        rd(0, CORE_LIM_ADDR, {1'b0, LIM_RST});
        rd(0, CORE_PRI_ADDR, {28'h0, CORE_PRI_RST});
        rd(0, UNC_PRI_ADDR, {28'h0, UNC_PRI_RST});
        rd(0, CORE_THR_ADDR, 33'h1_0000_0000);
        rd(0, MEM_LIM_ADDR, 33'h1_0000_0000);
        rd(1, UNC_LIM_ADDR, 33'h1_0000_0000);
        rd(1, UNC_PRI_ADDR, 33'h1_0000_0000);
        rd(0, 8'h3C, 33'h1_0000_0000);
        for (int i = 0; i < 6; i++) begin
            d = $random(seed) & 32'h7FFF_FFFF;
            wr(0, CORE_LIM_ADDR, d);
            rd(0, CORE_LIM_ADDR, {1'b0, d & PLANE_LIM_MASK});
            #1;
            check(36'(lim_c), 36'(d[14:0]));
            check(36'(en_c), 36'(d[15]));
            check(36'(clamp_c), 36'(d[15] & d[16]));
            check(win_c, win(d[23:17]));
            // Memory windows stay at most 2^3 times 1.3 units, under the reported maximum.
            d = d & 32'h7FC7_FFFF;
            wr(1, MEM_LIM_ADDR, d);
            rd(1, MEM_LIM_ADDR, {1'b0, d & MEM_LIM_MASK});
            #1;
            check(36'(lim_m), 36'(d[14:0]));
            check(36'(en_m), 36'(d[15]));
            check(win_m, win(d[23:17]));
        end
        wr(0, CORE_PRI_ADDR, 32'h0000_001F);
        apb(0, 1'b1, CORE_PRI_ADDR, 32'h0000_0005, 4'hE, 33'h0_0000_0000);
        rd(0, CORE_PRI_ADDR, 33'h0_0000_001F);
        #1;
        check(36'(pri_c), 36'h1F);
        wr(0, CORE_ENG_ADDR, 32'hFFFF_FFFF);
        rd(0, CORE_ENG_ADDR, 33'h0_0000_0000);
        // The locking write itself lands; later core limit and priority writes must bounce.
        wr(0, CORE_LIM_ADDR, 32'h8001_2345);
        wr(0, CORE_LIM_ADDR, 32'h0000_0ABC);
        wr(0, CORE_PRI_ADDR, 32'h0000_0003);
        rd(0, CORE_LIM_ADDR, 33'h0_8001_2345);
        rd(0, CORE_PRI_ADDR, 33'h0_0000_001F);
        wr(0, UNC_LIM_ADDR, 32'h0005_8777);
        wr(0, UNC_PRI_ADDR, 32'h0000_001E);
        rd(0, UNC_LIM_ADDR, 33'h0_0005_8777);
        rd(0, UNC_PRI_ADDR, 33'h0_0000_001E);
        #1;
        check(36'(lim_u), 36'h777);
        check(36'(en_u), 36'h1);
        check(36'(clamp_u), 36'h1);
        check(win_u, 36'd40);
        check(36'(pri_u), 36'h1E);
        wr(1, MEM_LIM_ADDR, 32'h8000_0100);
        wr(1, MEM_LIM_ADDR, 32'h0000_0200);
        rd(1, MEM_LIM_ADDR, 33'h0_8000_0100);
        wr(1, RANGE_LO_ADDR, 32'hFFFF_FFFF);
        rd(1, RANGE_LO_ADDR, {2'b00, MEM_MIN_PWR, 1'b0, MEM_TDP_PWR});
        rd(1, RANGE_HI_ADDR, {11'h000, MEM_MAX_WIN, 1'b0, MEM_MAX_PWR});
        @(posedge clk);
        inc_c <= 16'h0003;
        inc_u <= 16'h0005;
        inc_m <= 16'h0007;
        thr_c <= 1'b1;
        thr_m <= 1'b1;
        repeat (10) @(posedge clk);
        inc_c <= 16'h0000;
        inc_u <= 16'h0000;
        inc_m <= 16'h0000;
        thr_c <= 1'b0;
        thr_m <= 1'b0;
        unit <= 4'h5;
        repeat (45) @(posedge clk);
        rd(0, CORE_ENG_ADDR, 33'd30);
        rd(0, UNC_ENG_ADDR, 33'd50);
        rd(1, MEM_ENG_ADDR, 33'd70);
        rd(1, CORE_THR_ADDR, 33'd10);
        rd(1, MEM_THR_ADDR, 33'd10);
        // A two-cycle unit halves the count for the same throttled stretch.
        @(posedge clk);
        thr_c <= 1'b1;
        repeat (20) @(posedge clk);
        thr_c <= 1'b0;
        repeat (4) @(posedge clk);
        rd(1, CORE_THR_ADDR, 33'd20);
        // With the clock enable low nothing may count, however busy the inputs are.
        @(posedge clk);
        ce <= 1'b0;
        thr_c <= 1'b1;
        inc_c <= 16'h0100;
        repeat (10) @(posedge clk);
        ce <= 1'b1;
        thr_c <= 1'b0;
        inc_c <= 16'h0000;
        repeat (25) @(posedge clk);
        rd(1, CORE_THR_ADDR, 33'd20);
        rd(0, CORE_ENG_ADDR, 33'd30);
        do_reset();
        wr(0, CORE_LIM_ADDR, 32'h0000_0005);
        rd(0, CORE_LIM_ADDR, 33'h0_0000_0005);
        rd(1, MEM_ENG_ADDR, 33'h0_0000_0000);
        // Let the read checker judge the last access before the run ends.
        @(posedge clk);
        report_and_stop();
    end
endmodule // power_plane_limit_regs_tb
